// ---- common/dea_pkg.sv ----
package dea_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 10;
    localparam int          DEPTH      = 1024;
    localparam int          OFF_W      = 4;
    localparam int          PAGE_W     = 6;
    localparam int          PAGE_BYTES = 16;
    localparam int          HI_W       = 2;
    localparam logic [3:0]  OFF_MAX    = 4'hf;
    localparam logic [3:0]  OFF_ONE    = 4'h1;
    localparam logic [3:0]  OFF_ZERO   = 4'h0;
    localparam logic [7:0]  ERASED     = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US     = 1000;
    localparam int ERASE_T0_US   = 3200;
    localparam int WRITE_T0_US   = 2200;
    localparam int ERASE_T1_US   = 3700;
    localparam int WRITE_T1_US   = 3000;
    localparam int ERASE0_CYC    = ERASE_T0_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int WRITE0_CYC    = WRITE_T0_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int ERASE1_CYC    = ERASE_T1_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int WRITE1_CYC    = WRITE_T1_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int TMR_W         = 20;
    localparam logic [19:0] READ_CYC = 20'h00003;

    // ------------------------------------------------------------
    // control byte and software access
    // ------------------------------------------------------------
    typedef struct packed {
        logic timing_sel;
        logic wipe_arm;
        logic wipe_go;
        logic page_mode;
        logic program_arm;
        logic program_go;
        logic read_arm;
        logic read_go;
    } dea_ctrl_s;

    localparam dea_ctrl_s CTRL_RST = '0;

    typedef struct packed {
        logic       instr;
        logic       wr_ctrl;
        logic       wr_addr_hi;
        logic       wr_addr_lo;
        logic       wr_data;
        logic       done_clear;
        logic [7:0] wdata;
    } dea_sw_req_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_TIME,
        ST_COMMIT,
        ST_GO_CLR,
        ST_ARM_CLR
    } dea_state_e;

endpackage

// ---- hdl/dea_array.sv ----
`timescale 1ns/10ps

module dea_array (
    input  wire  logic                       ref_clk,
    input  wire  logic                       ce,
    input  wire  logic                       we,
    input  wire  logic [dea_pkg::ADDR_W-1:0] addr,
    input  wire  logic [7:0]                 wdata,
    output logic       [7:0]                 rdata
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // no reset: contents survive a reset like the real cells
    logic [7:0] mem [0:dea_pkg::DEPTH-1];

    always_ff @(posedge ref_clk) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end

endmodule // dea_array

// ---- hdl/dea_ctrl.sv ----
`timescale 1ns/10ps

module dea_ctrl #(
    parameter int ERASE0_CYC = dea_pkg::ERASE0_CYC,
    parameter int WRITE0_CYC = dea_pkg::WRITE0_CYC,
    parameter int ERASE1_CYC = dea_pkg::ERASE1_CYC,
    parameter int WRITE1_CYC = dea_pkg::WRITE1_CYC
) (
    input  wire  logic                      ref_clk,
    input  wire  logic                      resetn,
    input  wire  logic                      ce,
    input  wire  dea_pkg::dea_sw_req_s      sw_req,
    output dea_pkg::dea_ctrl_s              nv_control,
    output logic [dea_pkg::HI_W-1:0]        nv_addr_high,
    output logic [7:0]                      nv_addr_low,
    output logic [7:0]                      nv_data,
    output logic                            nv_done_flag,
    output logic                            nv_done_pulse,
    output logic                            nv_busy
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dea_pkg::dea_state_e      state_reg;
    dea_pkg::dea_state_e      state_next;
    dea_pkg::dea_ctrl_s       ctrl_reg;
    dea_pkg::dea_ctrl_s       ctrl_next;
    logic [dea_pkg::HI_W-1:0] addr_hi_reg;
    logic [7:0]               addr_lo_reg;
    logic [7:0]               data_reg;
    logic                     full_reg;
    logic                     wipe_raised_reg;
    logic                     prog_raised_reg;
    logic                     is_prog_reg;
    logic [dea_pkg::TMR_W-1:0] cnt_reg;
    logic [dea_pkg::OFF_W-1:0] ci_reg;
    logic                     done_reg;
    logic                     pulse_reg;
    logic [7:0]               buf_data [0:dea_pkg::PAGE_BYTES-1];
    logic [dea_pkg::PAGE_BYTES-1:0] tag_reg;

    // ------------------------------------------------------------
    // software request decode
    // ------------------------------------------------------------
    dea_pkg::dea_ctrl_s        wr_val;
    dea_pkg::dea_ctrl_s        accepted;
    wire  logic                idle      = (state_reg == dea_pkg::ST_IDLE);
    wire  logic                sw_ctrl   = sw_req.instr & sw_req.wr_ctrl
                                           & idle;
    wire  logic                sw_hi     = sw_req.instr & sw_req.wr_addr_hi
                                           & idle;
    wire  logic                sw_lo     = sw_req.instr & sw_req.wr_addr_lo
                                           & idle;
    wire  logic                sw_data   = sw_req.instr & sw_req.wr_data
                                           & idle;
    wire  logic [dea_pkg::OFF_W-1:0] off = addr_lo_reg[dea_pkg::OFF_W-1:0];
    wire  logic                off_sat   = (off == dea_pkg::OFF_MAX);
    wire  logic [dea_pkg::OFF_W-1:0] off_inc = off_sat ? off
                                           : off + dea_pkg::OFF_ONE;

    assign wr_val = dea_pkg::dea_ctrl_s'(sw_req.wdata);

    // erase and program go only count when their arm was raised by the instruction just before; read go needs only read_arm
    wire  logic er_start = sw_ctrl & wr_val.wipe_go & ctrl_reg.wipe_arm
                           & wipe_raised_reg;
    wire  logic wr_start = sw_ctrl & wr_val.program_go
                           & ctrl_reg.program_arm & prog_raised_reg
                           & ~er_start;
    wire  logic rd_start = sw_ctrl & wr_val.read_go & ctrl_reg.read_arm
                           & ~er_start & ~wr_start;

    // page data writes tag the buffer until one lands at the saturated offset
    wire  logic buf_load = sw_data & ctrl_reg.page_mode
                           & ~full_reg;

    always_comb begin
        accepted            = wr_val;
        accepted.wipe_go    = er_start;
        accepted.program_go = wr_start;
        accepted.read_go    = rd_start;
    end

    // ------------------------------------------------------------
    // timed cycle and commit walk
    // ------------------------------------------------------------
    // the cell timer is modelled on ref_clk; duration picked at launch
    wire  logic [dea_pkg::TMR_W-1:0] er_dur = ctrl_reg.timing_sel
        ? dea_pkg::TMR_W'(ERASE1_CYC - 1)
        : dea_pkg::TMR_W'(ERASE0_CYC - 1);
    wire  logic [dea_pkg::TMR_W-1:0] wr_dur = ctrl_reg.timing_sel
        ? dea_pkg::TMR_W'(WRITE1_CYC - 1)
        : dea_pkg::TMR_W'(WRITE0_CYC - 1);
    wire  logic cnt_zero  = (cnt_reg == '0);
    wire  logic page      = ctrl_reg.page_mode;
    wire  logic commit    = (state_reg == dea_pkg::ST_COMMIT);
    wire  logic commit_last = page ? (ci_reg == dea_pkg::OFF_MAX)
                            : (is_prog_reg ? (ci_reg == dea_pkg::OFF_ONE)
                                           : (ci_reg == dea_pkg::OFF_ZERO));

    // byte write: step 0 erases the cell, step 1 programs it
    wire  logic prog_step = is_prog_reg
                            & (page | (ci_reg == dea_pkg::OFF_ONE));
    wire  logic mem_we    = commit & (page ? tag_reg[ci_reg] : 1'b1);
    wire  logic [7:0] mem_wdata = prog_step
        ? (page ? buf_data[ci_reg] : data_reg)
        : dea_pkg::ERASED;
    wire  logic [dea_pkg::ADDR_W-1:0] cur_addr = {addr_hi_reg, addr_lo_reg};
    wire  logic [dea_pkg::ADDR_W-1:0] mem_addr = (commit & page)
        ? {cur_addr[dea_pkg::ADDR_W-1:dea_pkg::OFF_W], ci_reg}
        : cur_addr;
    logic [7:0] mem_rdata;
    wire  logic rd_done = (state_reg == dea_pkg::ST_READ) & cnt_zero;

    dea_array u_array (
        .ref_clk (ref_clk),
        .ce      (ce),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata   (mem_rdata)
    );

    // ------------------------------------------------------------
    // next state and control byte
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dea_pkg::ST_IDLE: begin
                if (er_start | wr_start) begin
                    state_next = dea_pkg::ST_TIME;
                end else if (rd_start) begin
                    state_next = dea_pkg::ST_READ;
                end
            end
            dea_pkg::ST_READ: begin
                if (cnt_zero) begin
                    state_next = dea_pkg::ST_IDLE;
                end
            end
            dea_pkg::ST_TIME: begin
                if (cnt_zero) begin
                    state_next = dea_pkg::ST_COMMIT;
                end
            end
            dea_pkg::ST_COMMIT: begin
                if (commit_last) begin
                    state_next = dea_pkg::ST_GO_CLR;
                end
            end
            dea_pkg::ST_GO_CLR:  state_next = dea_pkg::ST_ARM_CLR;
            dea_pkg::ST_ARM_CLR: state_next = dea_pkg::ST_IDLE;
            default:             state_next = dea_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        if (sw_ctrl) begin
            ctrl_next = accepted;
        end
        if (rd_done) begin
            ctrl_next.read_go = 1'b0;
        end
        if (state_reg == dea_pkg::ST_GO_CLR) begin
            ctrl_next.wipe_go    = 1'b0;
            ctrl_next.program_go = 1'b0;
        end
        if (state_reg == dea_pkg::ST_ARM_CLR) begin
            if (is_prog_reg) begin
                ctrl_next.program_arm = 1'b0;
            end else begin
                ctrl_next.wipe_arm = 1'b0;
            end
        end
    end

    // a falling erase or program arm, from software or hardware, empties the buffer
    wire  logic buf_clr = (ctrl_reg.wipe_arm & ~ctrl_next.wipe_arm)
                        | (ctrl_reg.program_arm
                           & ~ctrl_next.program_arm);
    wire  logic done_set = (state_reg == dea_pkg::ST_GO_CLR);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_reg <= dea_pkg::ST_IDLE;
            ctrl_reg  <= dea_pkg::CTRL_RST;
        end else if (ce) begin
            state_reg <= state_next;
            ctrl_reg  <= ctrl_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wipe_raised_reg <= 1'b0;
            prog_raised_reg <= 1'b0;
        end else if (ce & sw_req.instr) begin
            wipe_raised_reg <= sw_ctrl & wr_val.wipe_arm
                               & ~ctrl_reg.wipe_arm;
            prog_raised_reg <= sw_ctrl & wr_val.program_arm
                               & ~ctrl_reg.program_arm;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_reg     <= '0;
            ci_reg      <= dea_pkg::OFF_ZERO;
            is_prog_reg <= 1'b0;
        end else if (ce) begin
            if (er_start | wr_start) begin
                cnt_reg     <= er_start ? er_dur : wr_dur;
                is_prog_reg <= wr_start;
                ci_reg      <= dea_pkg::OFF_ZERO;
            end else if (rd_start) begin
                cnt_reg <= dea_pkg::READ_CYC;
            end else if (!cnt_zero) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            if (commit & !commit_last) begin
                ci_reg <= ci_reg + dea_pkg::OFF_ONE;
            end
        end
    end

    // address: page bits only change by software, offset walks
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            addr_hi_reg <= '0;
            addr_lo_reg <= '0;
            full_reg    <= 1'b0;
        end else if (ce) begin
            if (sw_hi) begin
                addr_hi_reg <= sw_req.wdata[dea_pkg::HI_W-1:0];
            end
            if (sw_lo) begin
                addr_lo_reg <= sw_req.wdata;
                full_reg    <= 1'b0;
            end else if (buf_load | (rd_done & page)) begin
                addr_lo_reg[dea_pkg::OFF_W-1:0] <= off_inc;
                if (buf_load & off_sat) begin
                    full_reg <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            data_reg <= '0;
        end else if (ce) begin
            if (rd_done) begin
                data_reg <= mem_rdata;
            end else if (sw_data) begin
                data_reg <= sw_req.wdata;
            end
        end
    end

    // software clear loses to a completion in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            done_reg  <= 1'b0;
            pulse_reg <= 1'b0;
        end else if (ce) begin
            done_reg  <= done_set | (done_reg & ~sw_req.done_clear);
            pulse_reg <= done_set;
        end
    end

    // ------------------------------------------------------------
    // page buffer
    // ------------------------------------------------------------
    for (genvar i = 0; i < dea_pkg::PAGE_BYTES; i++) begin : g_buf
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                buf_data[i] <= '0;
                tag_reg[i]  <= 1'b0;
            end else if (ce) begin
                if (buf_clr) begin
                    buf_data[i] <= '0;
                    tag_reg[i]  <= 1'b0;
                end else if (buf_load
                             & (off == dea_pkg::OFF_W'(i))) begin
                    buf_data[i] <= sw_req.wdata;
                    tag_reg[i]  <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic busy_reg;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
        end else if (ce) begin
            busy_reg <= (state_next != dea_pkg::ST_IDLE);
        end
    end

    assign nv_control    = ctrl_reg;
    assign nv_addr_high  = addr_hi_reg;
    assign nv_addr_low   = addr_lo_reg;
    assign nv_data       = data_reg;
    assign nv_done_flag  = done_reg;
    assign nv_done_pulse = pulse_reg;
    assign nv_busy       = busy_reg;

endmodule // dea_ctrl

// ---- bench/dea_ctrl_monitor.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------
// port checks for the access controller
// ----------------------------------------------------------------
module dea_ctrl_monitor (
    input wire logic                      ref_clk,
    input wire logic                      resetn,
    input wire logic                      ce,
    input wire dea_pkg::dea_sw_req_s      sw_req,
    input wire dea_pkg::dea_ctrl_s        nv_control,
    input wire logic [dea_pkg::HI_W-1:0]  nv_addr_high,
    input wire logic [7:0]                nv_addr_low,
    input wire logic [7:0]                nv_data,
    input wire logic                      nv_done_flag,
    input wire logic                      nv_done_pulse,
    input wire logic                      nv_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // an address write is the only legal cause of a page change
    wire addr_wr = sw_req.instr && (sw_req.wr_addr_lo || sw_req.wr_addr_hi);

    sequence s_read_run;
        nv_control.read_go [*4] ##1 !nv_control.read_go;
    endsequence
    sequence s_done_step;
        (nv_done_flag && !nv_control.wipe_go && !nv_control.program_go)
            ##1 (!nv_control.wipe_arm && !nv_control.program_arm);
    endsequence

    chk_read_arm: assert property (
        $rose(nv_control.read_go) |-> $past(nv_control.read_arm))
        else $error("read started without read arm");
    chk_read_span: assert property (
        $rose(nv_control.read_go) |-> s_read_run)
        else $error("read strobe length wrong");
    chk_page_step: assert property (
        $fell(nv_control.read_go) && nv_control.page_mode
        && $past(nv_addr_low[3:0]) != 4'hf
        |-> nv_addr_low[3:0] == $past(nv_addr_low[3:0]) + 4'h1)
        else $error("page read did not step offset");
    chk_page_fixed: assert property (
        !$past(addr_wr) |-> nv_addr_high == $past(nv_addr_high)
        && nv_addr_low[7:4] == $past(nv_addr_low[7:4])
        && ($past(nv_addr_low[3:0]) != 4'hf || nv_addr_low[3:0] == 4'hf))
        else $error("page bits moved or offset wrapped");
    chk_wipe_arm: assert property (
        $rose(nv_control.wipe_go) |-> $past(nv_control.wipe_arm))
        else $error("erase started without arm");
    chk_prog_arm: assert property (
        $rose(nv_control.program_go) |-> $past(nv_control.program_arm))
        else $error("write started without arm");
    chk_wipe_finish: assert property (
        $fell(nv_control.wipe_go) |-> nv_done_pulse
        ##1 $fell(nv_control.wipe_arm))
        else $error("erase end order wrong");
    chk_prog_finish: assert property (
        $fell(nv_control.program_go) |-> nv_done_pulse
        ##1 $fell(nv_control.program_arm))
        else $error("write end order wrong");
    chk_done_close: assert property (
        nv_done_pulse |-> s_done_step)
        else $error("done pulse without finish");
    chk_reset_clear: assert property (
        disable iff (1'b0) !resetn |=> nv_control == '0 && !nv_busy)
        else $error("control not cleared by reset");
endmodule // dea_ctrl_monitor

bind dea_ctrl dea_ctrl_monitor chk_u (.ref_clk, .resetn, .ce, .sw_req,
    .nv_control, .nv_addr_high, .nv_addr_low, .nv_data, .nv_done_flag,
    .nv_done_pulse, .nv_busy);

// ---- bench/data_eeprom_access_controller_test.sv ----
`timescale 1ns/10ps

module data_eeprom_access_controller_test;
    // short cycle counts keep the run brief
    localparam int E0 = 20;
    localparam int W0 = 15;
    localparam int E1 = 25;
    localparam int W1 = 18;
    localparam int CT = 0;
    localparam int AH = 1;
    localparam int AL = 2;
    localparam int DT = 3;
    localparam int DC = 4;

    logic                  ref_clk;
    logic                  resetn;
    logic                  ce;
    dea_pkg::dea_sw_req_s  sw_req;
    dea_pkg::dea_ctrl_s    nv_control;
    logic [1:0]            nv_addr_high;
    logic [7:0]            nv_addr_low;
    logic [7:0]            nv_data;
    logic                  nv_done_flag;
    logic                  nv_done_pulse;
    logic                  nv_busy;
    int                    n_errors;
    int                    checks_done;

    dea_ctrl #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1),
        .WRITE1_CYC(W1)) dut_u (.ref_clk, .resetn, .ce, .sw_req,
        .nv_control, .nv_addr_high, .nv_addr_low, .nv_data,
        .nv_done_flag, .nv_done_pulse, .nv_busy);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one instruction cycle, then an idle cycle
    task automatic op(input int kind, input logic [7:0] d);
        dea_pkg::dea_sw_req_s r;
        r = '0;
        r.instr = (kind != DC);
        r.wr_ctrl = (kind == CT);
        r.wr_addr_hi = (kind == AH);
        r.wr_addr_lo = (kind == AL);
        r.wr_data = (kind == DT);
        r.done_clear = (kind == DC);
        r.wdata = d;
        @(negedge ref_clk);
        sw_req = r;
        @(negedge ref_clk);
        sw_req = '0;
    endtask

    task automatic wait_idle(output int cyc);
        cyc = 0;
        do begin
            @(negedge ref_clk);
            cyc++;
        end while (nv_busy !== 1'b0 && cyc < 200);
        if (cyc >= 200) begin
            n_errors++;
            $display("unexpected at %0t: busy %h exp %h", $time, nv_busy, 0);
            final_report();
        end
    endtask

    task automatic read_one(input logic [7:0] ctrl, input logic [7:0] exp);
        int c;
        op(CT, ctrl);
        check({7'h00, nv_control.read_go}, 8'h01);
        wait_idle(c);
        check(nv_control, ctrl & 8'hfe);
        check(nv_data, exp);
    endtask

    // arm, go in the next instruction cycle, then time the busy span
    task automatic prog(input logic [7:0] arm, input logic [7:0] go,
                        input int dur, input int commit, input bit poke);
        int c;
        op(CT, arm);
        op(CT, go);
        if (poke) begin
            op(AL, 8'h00);
        end
        wait_idle(c);
        check({7'h00, c >= dur + commit && c <= dur + commit + 6}, 8'h01);
        check(nv_control, arm & 8'h90);
        check({7'h00, nv_done_flag}, 8'h01);
        if (poke) begin
            check(nv_addr_low, 8'h35);
        end
        op(DC, 8'h00);
        check({7'h00, nv_done_flag}, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check(nv_control, 8'h00);
        check({6'h00, nv_addr_high}, 8'h00);
        check(nv_data, 8'h00);
    endtask

    task automatic t_byte();
        op(AH, 8'h01);
        op(AL, 8'h35);
        op(DT, 8'ha5);
        prog(8'h08, 8'h0c, W0, 2, 1'b1);
        op(CT, 8'h02);
        read_one(8'h03, 8'ha5);
    endtask

    task automatic t_refuse();
        op(CT, 8'h00);
        op(CT, 8'h01);
        check(nv_control, 8'h00);
        op(CT, 8'h04);
        check(nv_control, 8'h00);
        op(CT, 8'h08);
        op(AL, 8'h35);
        op(CT, 8'h0c);
        check(nv_control, 8'h08);
        op(CT, 8'h40);
        op(AL, 8'h35);
        op(CT, 8'h60);
        check(nv_control, 8'h40);
        op(CT, 8'h00);
        check(nv_data, 8'ha5);
    endtask

    // erase also wipes the byte written earlier at offset 5
    task automatic t_erase();
        op(CT, 8'h10);
        op(AL, 8'h30);
        for (int i = 0; i < 16; i++) begin
            op(DT, 8'h5a);
        end
        check(nv_addr_low, 8'h3f);
        prog(8'h50, 8'h70, E0, 16, 1'b0);
        op(AL, 8'h30);
        op(CT, 8'h12);
        for (int i = 0; i < 16; i++) begin
            read_one(8'h13, 8'h00);
        end
        check(nv_addr_low, 8'h3f);
    endtask

    // seventeenth byte must be dropped once the offset sits at 0fh
    task automatic t_pwrite();
        op(CT, 8'h10);
        op(AL, 8'h30);
        for (int i = 0; i < 17; i++) begin
            op(DT, 8'h40 + 8'(i));
        end
        check(nv_addr_low, 8'h3f);
        prog(8'h98, 8'h9c, W1, 16, 1'b0);
        op(AL, 8'h30);
        op(CT, 8'h12);
        for (int i = 0; i < 16; i++) begin
            read_one(8'h13, 8'h40 + 8'(i));
        end
    endtask

    // a falling arm empties the buffer, so the later cycle writes nothing
    task automatic t_drop(input logic [7:0] arm, input logic [7:0] go,
                          input int dur);
        op(CT, 8'h10);
        op(AL, 8'h31);
        op(DT, 8'h77);
        op(CT, arm);
        op(CT, 8'h10);
        op(AL, 8'h31);
        prog(arm, go, dur, 16, 1'b0);
        op(AL, 8'h31);
        op(CT, 8'h12);
        read_one(8'h13, 8'h41);
    endtask

    // low enable stretches a byte erase on the long timing
    task automatic t_freeze();
        int c;
        op(CT, 8'h00);
        op(AH, 8'h02);
        op(AL, 8'h07);
        op(CT, 8'hc0);
        op(CT, 8'he0);
        ce = 1'b0;
        repeat (30) @(negedge ref_clk);
        check(nv_control, 8'he0);
        check({7'h00, nv_busy}, 8'h01);
        ce = 1'b1;
        c = 0;
        while (nv_done_pulse !== 1'b1 && c < 60) begin
            @(negedge ref_clk);
            c++;
        end
        check(8'(c), 8'h1b);
        if (c >= 60) begin
            final_report();
        end
        check(nv_control, 8'hc0);
        @(negedge ref_clk);
        check(nv_control, 8'h80);
        check({7'h00, nv_done_pulse}, 8'h00);
        op(CT, 8'h02);
        read_one(8'h03, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        sw_req = '0;
        n_errors = 0;
        checks_done = 0;
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
        t_reset();
        t_byte();
        t_refuse();
        t_erase();
        t_pwrite();
        t_drop(8'h18, 8'h1c, W0);
        t_drop(8'h50, 8'h70, E0);
        t_freeze();
        final_report();
    end
endmodule // data_eeprom_access_controller_test
